// ---- src/supply_monitor_pkg.sv ----
/*
 * Constants, field layout and carrier types of the supply monitor control block.
 * Assumes a single system clock; the comparators are asynchronous to it.
 */
// Functional notes
// - Bit 7 follows the upper threshold comparator
// - Bit 6 follows the lower threshold comparator
// - Bit 5 sets above upper, clears below lower
// - Plug request on bit 5 rising, when enabled
// - Bit 4 read/write plug interrupt enable
// - Bits 3:2 read/write regulator level select
// - Bit 1 disables detector, forces bits 7:5
// - Bit 0 read/write regulator power on
// - Reset clears all eight control bits
package supply_monitor_pkg;

	localparam int          ADDR_W          = 4;
	localparam int          DATA_W          = 32;
	localparam int          REG_W           = 8;

	// Byte addresses of the word registers
	localparam logic [3:0]  OFS_POWER_CTRL  = 4'h0;
	localparam logic [3:0]  OFS_IRQ_STATUS  = 4'h4;
	localparam logic [3:0]  OFS_IRQ_MASK    = 4'h8;

	// Power control field positions
	localparam int          BIT_UPPER       = 7;
	localparam int          BIT_LOWER       = 6;
	localparam int          BIT_PRESENT     = 5;
	localparam int          BIT_PLUG_IE     = 4;
	localparam int          BIT_LEVEL_HI    = 3;
	localparam int          BIT_LEVEL_LO    = 2;
	localparam int          BIT_DET_OFF     = 1;
	localparam int          BIT_REG_ON      = 0;

	// Interrupt status layout
	localparam int          IRQ_W           = 2;
	localparam int          IRQ_PLUG        = 0;
	localparam int          IRQ_UNPLUG      = 1;

	localparam logic [7:0]  POWER_CTRL_RST  = 8'h00;
	localparam logic [1:0]  IRQ_RST         = 2'h0;
	localparam logic [DATA_W-1:0] RD_ZERO   = 32'h0000_0000;

	typedef struct packed {
		logic [1:0] syncUpper;
		logic [1:0] syncLower;
		logic       present;
		logic       plugIe;
		logic [1:0] levelSel;
		logic       detOff;
		logic       regOn;
		logic [IRQ_W-1:0] irqStatus;
		logic [IRQ_W-1:0] irqMask;
		logic       plugReq;
		logic       ack;
		logic [DATA_W-1:0] rdData;
	} state_s;

endpackage

// ---- src/usb_supply_monitor_control.sv ----
/*
 * Power control register bank with USB supply threshold flags, cable-present
 * hysteresis, plug interrupt, regulator and detector controls.
 * Assumes an Avalon-MM master on clk and asynchronous comparator inputs.
 */
`timescale 1ns/1ps
module usb_supply_monitor_control
	import supply_monitor_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              nrst,
	input  wire logic [ADDR_W-1:0] address,
	input  wire logic              read,
	input  wire logic              write,
	input  wire logic [DATA_W-1:0] writedata,
	input  wire logic [3:0]        byteenable,
	output logic      [DATA_W-1:0] readdata,
	output logic                   waitrequest,
	input  wire logic              usbAboveUpper,
	input  wire logic              usbAboveLower,
	output logic                   detectorPowerOff,
	output logic                   mediaRegulatorOn,
	output logic      [1:0]        regulatorLevelSelect,
	output logic                   plugIrqReq,
	output logic                   irq
);

	state_s state_q;
	state_s state_d;
	logic   upperFlag;
	logic   lowerFlag;
	logic   presentFlag;
	logic   req;
	logic   wrEn;
	logic   rdEn;
	logic [REG_W-1:0] ctrlView;

	always_comb begin
		req  = (read || write) && !state_q.ack;
		// A write lands only at the edge where waitrequest is seen low
		wrEn = write && state_q.ack && byteenable[0];
		rdEn = read && req;
		upperFlag   = state_q.detOff | state_q.syncUpper[1];
		lowerFlag   = state_q.detOff | state_q.syncLower[1];
		presentFlag = state_q.detOff | state_q.present;
		ctrlView = {upperFlag, lowerFlag, presentFlag, state_q.plugIe,
			state_q.levelSel, state_q.detOff, state_q.regOn};

		state_d = state_q;
		state_d.syncUpper = {state_q.syncUpper[0], usbAboveUpper};
		state_d.syncLower = {state_q.syncLower[0], usbAboveLower};
		// Hysteresis: set above upper, clear only below lower
		if (state_q.syncUpper[1]) begin
			state_d.present = 1'b1;
		end else if (!state_q.syncLower[1]) begin
			state_d.present = 1'b0;
		end
		state_d.plugReq = 1'b0;
		state_d.ack = req;

		// Writes to status clear ones; new events still win below
		if (wrEn && address == OFS_IRQ_STATUS) begin
			state_d.irqStatus = state_q.irqStatus & ~writedata[IRQ_W-1:0];
		end
		if (wrEn && address == OFS_IRQ_MASK) begin
			state_d.irqMask = writedata[IRQ_W-1:0];
		end
		if (wrEn && address == OFS_POWER_CTRL) begin
			// Bits 7:5 not written
			state_d.plugIe   = writedata[BIT_PLUG_IE];
			state_d.levelSel = writedata[BIT_LEVEL_HI:BIT_LEVEL_LO];
			state_d.detOff   = writedata[BIT_DET_OFF];
			state_d.regOn    = writedata[BIT_REG_ON];
		end

		if (presentFlag == 1'b0 && (state_d.detOff | state_d.present)) begin
			state_d.irqStatus[IRQ_PLUG] = 1'b1;
			state_d.plugReq = state_q.plugIe;
		end
		if (presentFlag == 1'b1 && !(state_d.detOff | state_d.present)) begin
			state_d.irqStatus[IRQ_UNPLUG] = 1'b1;
		end

		state_d.rdData = RD_ZERO;
		if (rdEn) begin
			unique case (address)
				OFS_POWER_CTRL: state_d.rdData = {24'h00_0000, ctrlView};
				OFS_IRQ_STATUS: state_d.rdData = {30'h0000_0000, state_q.irqStatus};
				OFS_IRQ_MASK:   state_d.rdData = {30'h0000_0000, state_q.irqMask};
				default:        state_d.rdData = RD_ZERO;
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign waitrequest          = (read || write) && !state_q.ack;
	assign readdata             = state_q.rdData;
	assign detectorPowerOff     = state_q.detOff;
	assign mediaRegulatorOn     = state_q.regOn;
	assign regulatorLevelSelect = state_q.levelSel;
	assign plugIrqReq           = state_q.plugReq;
	assign irq                  = |(state_q.irqStatus & state_q.irqMask);

	AST_UPPER_FOLLOWS: assert property (@(posedge clk) disable iff (!nrst)
		!state_q.detOff && $past(usbAboveUpper, 2) && $past(usbAboveUpper, 3)
		&& !$past(state_q.detOff) |-> upperFlag) else $error("upper flag lags");
	AST_LOWER_FOLLOWS: assert property (@(posedge clk) disable iff (!nrst)
		!state_q.detOff && !$past(usbAboveLower, 2) && !$past(usbAboveLower, 3)
		|-> !lowerFlag) else $error("lower flag stuck");
	AST_HYSTERESIS: assert property (@(posedge clk) disable iff (!nrst)
		state_q.syncLower[1] && !state_q.syncUpper[1] |=> $stable(state_q.present))
		else $error("present changed inside band");
	AST_NO_REQ_DISABLED: assert property (@(posedge clk) disable iff (!nrst)
		!state_q.plugIe |=> !plugIrqReq) else $error("request while disabled");
	AST_NO_REQ_FALL: assert property (@(posedge clk) disable iff (!nrst)
		plugIrqReq |-> presentFlag) else $error("request on falling edge");
	AST_IE_WRITE: assert property (@(posedge clk) disable iff (!nrst)
		wrEn && address == OFS_POWER_CTRL |=> state_q.plugIe == $past(writedata[BIT_PLUG_IE])
		&& regulatorLevelSelect == $past(writedata[BIT_LEVEL_HI:BIT_LEVEL_LO]))
		else $error("control write lost");
	AST_DET_FORCE: assert property (@(posedge clk) disable iff (!nrst)
		detectorPowerOff |-> ctrlView[BIT_UPPER:BIT_PRESENT] == 3'h7)
		else $error("flags not forced");
	AST_REG_WRITE: assert property (@(posedge clk) disable iff (!nrst)
		wrEn && address == OFS_POWER_CTRL |=> mediaRegulatorOn == $past(writedata[BIT_REG_ON]))
		else $error("regulator enable lost");
	AST_RO_BITS: assert property (@(posedge clk) disable iff (!nrst)
		wrEn && address == OFS_POWER_CTRL && state_q.syncLower[1] && !state_q.syncUpper[1]
		&& !state_q.detOff |=> $stable(state_q.present)) else $error("read-only written");

endmodule

// ---- verif/testbench.sv ----
/* Self-checking bench for the supply monitor control register bank.
   Assumes the package and design files are compiled before this one. */
`timescale 1ns/1ps
module testbench
	import supply_monitor_pkg::*;
;
	logic              clk, nrst, read, write, waitrequest, irq, plugIrqReq;
	logic [ADDR_W-1:0] address;
	logic [DATA_W-1:0] writedata, readdata;
	logic [3:0]        byteenable;
	logic              usbAboveUpper, usbAboveLower, detectorPowerOff, mediaRegulatorOn;
	logic [1:0]        regulatorLevelSelect;
	int                error_cnt, checks_done, pulses;

	usb_supply_monitor_control dut (.clk(clk), .nrst(nrst), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .usbAboveUpper(usbAboveUpper),
		.usbAboveLower(usbAboveLower), .detectorPowerOff(detectorPowerOff),
		.mediaRegulatorOn(mediaRegulatorOn), .regulatorLevelSelect(regulatorLevelSelect),
		.plugIrqReq(plugIrqReq), .irq(irq));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// Plug request is a one-cycle pulse, so count every one seen
	always @(posedge clk) if (plugIrqReq === 1'b1) pulses++;

	task test_done();
		$display("Checks %0d, mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// One Avalon transfer, held until waitrequest is seen low at an edge
	task acc(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		address <= a;
		write <= w;
		read <= ~w;
		writedata <= d;
		do begin
			@(posedge clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 20);
		if (waitrequest !== 1'b0) begin
			error_cnt++;
			test_done();
		end
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask

	task wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] q;
		acc(1'b1, a, d, q);
	endtask

	task rd(input string nm, input logic [3:0] a, input logic [31:0] e);
		logic [31:0] q;
		acc(1'b0, a, 32'h0000_0000, q);
		chk(nm, q, e);
	endtask

	task settle();
		repeat (6) @(posedge clk);
	endtask

	initial begin
		{nrst, read, write, usbAboveUpper, usbAboveLower} = 5'h00;
		address = '0;
		writedata = '0;
		byteenable = 4'hf;
		{error_cnt, checks_done, pulses} = {32'd0, 32'd0, 32'd0};
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		rd("ctrl", OFS_POWER_CTRL, 32'h0000_0000);
		chk("outs", {28'h0, detectorPowerOff, mediaRegulatorOn, regulatorLevelSelect}, 0);
		for (int i = 0; i < 4; i++) begin
			wr(OFS_POWER_CTRL, 32'h0000_00E1 | (32'(i) << 2));
			rd("ctrl", OFS_POWER_CTRL, 32'h0000_0001 | (32'(i) << 2));
			chk("level", 32'(regulatorLevelSelect), 32'(i));
		end
		chk("regOn", 32'(mediaRegulatorOn), 32'h0000_0001);
		byteenable <= 4'h0;
		wr(OFS_POWER_CTRL, 32'h0000_0000);
		byteenable <= 4'hf;
		rd("noLane", OFS_POWER_CTRL, 32'h0000_000D);
		wr(OFS_POWER_CTRL, 32'h0000_0010);
		wr(OFS_IRQ_MASK, 32'h0000_0001);
		usbAboveLower <= 1'b1;
		settle();
		rd("lower", OFS_POWER_CTRL, 32'h0000_0050);
		usbAboveUpper <= 1'b1;
		settle();
		rd("plug", OFS_POWER_CTRL, 32'h0000_00F0);
		chk("pulse", 32'(pulses), 32'h0000_0001);
		chk("irq", 32'(irq), 32'h0000_0001);
		rd("status", OFS_IRQ_STATUS, 32'h0000_0001);
		wr(OFS_IRQ_STATUS, 32'h0000_0001);
		@(posedge clk);
		chk("irqClr", 32'(irq), 32'h0000_0000);
		usbAboveUpper <= 1'b0;
		settle();
		rd("hyst", OFS_POWER_CTRL, 32'h0000_0070);
		usbAboveLower <= 1'b0;
		settle();
		rd("unplug", OFS_POWER_CTRL, 32'h0000_0010);
		chk("noFall", 32'(pulses), 32'h0000_0001);
		// Stand-alone: regulator off, media switch is a software-driven pin
		wr(OFS_POWER_CTRL, 32'h0000_0000);
		wr(OFS_POWER_CTRL, 32'h0000_0002);
		settle();
		rd("detOff", OFS_POWER_CTRL, 32'h0000_00E2);
		chk("detPin", 32'(detectorPowerOff), 32'h0000_0001);
		chk("ieOff", 32'(pulses), 32'h0000_0001);
		rd("unmapped", 4'hC, 32'h0000_0000);
		// Reset pulse on nrst after plug service
		nrst <= 1'b0;
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		rd("rst2", OFS_POWER_CTRL, 32'h0000_0000);
		chk("rst2Pin", 32'(detectorPowerOff), 32'h0000_0000);
		test_done();
	end
endmodule
